// [pkg/aedf_pkg.sv]
// Shared constants and types for the ATA command interpreter block
package aedf_pkg;

   // ------------------------------------------------------------
   // Task file register addresses
   // ------------------------------------------------------------
   localparam logic [2:0] TF_DATA      = 3'h0;
   localparam logic [2:0] TF_FEAT_ERR  = 3'h1;
   localparam logic [2:0] TF_COUNT     = 3'h2;
   localparam logic [2:0] TF_ADDR_LOW  = 3'h3;
   localparam logic [2:0] TF_ADDR_MID  = 3'h4;
   localparam logic [2:0] TF_ADDR_HIGH = 3'h5;
   localparam logic [2:0] TF_DRV_HEAD  = 3'h6;
   localparam logic [2:0] TF_CMD_STAT  = 3'h7;

   // ------------------------------------------------------------
   // Opcodes
   // ------------------------------------------------------------
   localparam logic [7:0] OP_ERASE = 8'hc0;
   localparam logic [7:0] OP_DIAG  = 8'h90;
   localparam logic [7:0] OP_FLUSH = 8'he7;
   localparam logic [7:0] OP_IDENT = 8'hec;

   // ------------------------------------------------------------
   // Status and error fields
   // ------------------------------------------------------------
   localparam int         ST_BSY_BIT  = 7;
   localparam int         ST_RDY_BIT  = 6;
   localparam int         ST_DWF_BIT  = 5;
   localparam int         ST_DSC_BIT  = 4;
   localparam int         ST_DRQ_BIT  = 3;
   localparam int         ST_ERR_BIT  = 0;
   localparam int         DH_DRV_BIT  = 4;
   localparam logic [7:0] STAT_RESET  = 8'h50;
   localparam logic [7:0] ERR_NONE    = 8'h00;
   localparam logic [7:0] ERR_ABORT   = 8'h04;

   // Diagnostic result codes
   localparam logic [7:0] DIAG_OK        = 8'h01;
   localparam logic [7:0] DIAG_FORMATTER = 8'h02;
   localparam logic [7:0] DIAG_BUFFER    = 8'h03;
   localparam logic [7:0] DIAG_ECC       = 8'h04;
   localparam logic [7:0] DIAG_CPU       = 8'h05;

   // ------------------------------------------------------------
   // Identify block contents
   // ------------------------------------------------------------
   localparam logic [7:0]  ID_LAST_WORD = 8'hff;
   localparam logic [15:0] ID_CFG_FIXED = 16'h044a;
   localparam logic [15:0] ID_CFG_REMOV = 16'h848a;
   localparam logic [15:0] ID_BUF_TYPE  = 16'h0002;
   localparam logic [15:0] ID_BUF_SIZE  = 16'h0002;
   localparam logic [15:0] ID_MULT_MAX  = 16'h8001;
   localparam logic [15:0] ID_DWORD     = 16'h0000;
   localparam logic [15:0] ID_CAPAB     = 16'h0f00;

   // ------------------------------------------------------------
   // Carriers
   // ------------------------------------------------------------
   typedef struct packed {
      logic [2:0]  addr;
      logic        wr;
      logic        rd;
      logic [15:0] wdata;
   } aedf_tf_req_t;

   typedef struct packed {
      logic        erase;
      logic        flush;
      logic        diag;
      logic [27:0] lba;
      logic [8:0]  count;
   } aedf_media_req_t;

   typedef struct packed {
      logic       done;
      logic       fault;
      logic [7:0] diag_code;
   } aedf_media_rsp_t;

   typedef enum {
      S_IDLE, S_ERASE, S_DIAG, S_FLUSH, S_IDENT
   } aedf_state_t;

endpackage : aedf_pkg

// [rtl/aedf_core.sv]
// Task-file command interpreter: erase, diagnostic, flush, identify
`timescale 1ns/1ps

// What this block does
// - Erase opcode pre-conditions sectors for later writes without erase
// - Erase has no data phase; a media failure reports write fault
// - Erase start address from head, high, mid, low bytes; count from count reg
// - Diagnostic runs regardless of drive bit; reports only its own media code
// - Diagnostic code enters error register only when command finishes
// - Diagnostic codes: 01 ok, 02 formatter, 03 buffer, 04 ECC, 05 CPU
// - Flush writes cached data first, then reports ready and seek done
// - Build without flush support aborts the flush opcode
// - Identify returns its block with the single-sector read handshake
// - Reserved identify bits and words read as zero
// - Word 0 is 044Ah fixed, optionally 848Ah removable
// - Words 7 and 8 hold total sectors, word 7 the high half
// - Words 10 to 19 hold serial number, 20 right-justified ASCII bytes
// - Word 20 is 0002h; word 21 buffer size, default 0002h
// - Words 23 to 26 firmware revision, big-endian bytes per word
// - Words 27 to 46 model number, 40 right-justified ASCII bytes
// - Word 47 reads 8001h
// - Word 48 reads 0000h, no double-word transfers
// - Word 49 reads 0F00h capabilities
// - Drive-only commands honour drive bit and ignore head bits
module aedf_core #(
   parameter logic [31:0]  CAPACITY  = 32'h0001_0000,
   parameter bit           DEV_BIT   = 1'b0,
   parameter bit           FLUSH_EN  = 1'b1,
   parameter bit           REMOVABLE = 1'b0,
   parameter logic [15:0]  BUF_SIZE  = aedf_pkg::ID_BUF_SIZE,
   parameter logic [159:0] SERIAL    = {{12{8'h20}}, "SN000001"},
   parameter logic [63:0]  FW_REV    = "REV1.000",
   parameter logic [319:0] MODEL     = {{32{8'h20}}, "SSD-CORE"}
) (
   input  wire logic                      clk_in,
   input  wire logic                      reset_in,
   input  wire aedf_pkg::aedf_tf_req_t    tf_req_in,
   output logic [15:0]                    tf_rdata_out,
   output aedf_pkg::aedf_media_req_t      media_req_out,
   input  wire aedf_pkg::aedf_media_rsp_t media_rsp_in
);
   import aedf_pkg::*;

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   aedf_state_t state;
   logic [7:0]  feat;
   logic [7:0]  count;
   logic [7:0]  addr_low;
   logic [7:0]  addr_mid;
   logic [7:0]  addr_high;
   logic [7:0]  drv_head;
   logic [7:0]  status;
   logic [7:0]  error;
   logic [7:0]  word_idx;

   // ------------------------------------------------------------
   // Identify word lookup
   // ------------------------------------------------------------
   // Table fixed by parameters, so a data read is one mux deep
   wire [15:0] id_rom [0:255];

   for (genvar g = 0; g < 256; g++) begin : g_id_word
      if (g == 0) begin : g_config
         assign id_rom[g] = REMOVABLE ? ID_CFG_REMOV : ID_CFG_FIXED;
      end else if (g == 7) begin : g_cap_high
         assign id_rom[g] = CAPACITY[31:16];
      end else if (g == 8) begin : g_cap_low
         assign id_rom[g] = CAPACITY[15:0];
      end else if (g >= 10 && g <= 19) begin : g_serial
         assign id_rom[g] = SERIAL[159 - 16 * (g - 10) -: 16];
      end else if (g == 20) begin : g_buf_type
         assign id_rom[g] = ID_BUF_TYPE;
      end else if (g == 21) begin : g_buf_size
         assign id_rom[g] = BUF_SIZE;
      end else if (g >= 23 && g <= 26) begin : g_firmware
         assign id_rom[g] = FW_REV[63 - 16 * (g - 23) -: 16];
      end else if (g >= 27 && g <= 46) begin : g_model
         assign id_rom[g] = MODEL[319 - 16 * (g - 27) -: 16];
      end else if (g == 47) begin : g_mult_max
         assign id_rom[g] = ID_MULT_MAX;
      end else if (g == 48) begin : g_dword
         assign id_rom[g] = ID_DWORD;
      end else if (g == 49) begin : g_capab
         assign id_rom[g] = ID_CAPAB;
      end else begin : g_reserved
         assign id_rom[g] = 16'h0000;
      end
   end

   // ------------------------------------------------------------
   // Decode
   // ------------------------------------------------------------
   wire        busy      = (state != S_IDLE);
   wire        reg_wr    = tf_req_in.wr && !busy;
   wire [7:0]  wbyte     = tf_req_in.wdata[7:0];
   wire        cmd_wr    = reg_wr && (tf_req_in.addr == TF_CMD_STAT);
   wire        is_diag   = (wbyte == OP_DIAG);
   // Head bits play no part in selection
   wire        dev_match = (drv_head[DH_DRV_BIT] == DEV_BIT);
   wire        cmd_take  = cmd_wr && (dev_match || is_diag);
   wire [27:0] start_lba = {drv_head[3:0], addr_high, addr_mid,
                            addr_low};
   // A count of zero means 256 blocks
   wire [8:0]  erase_cnt = (count == 8'h00) ? 9'h100 : {1'b0, count};
   wire [32:0] erase_end = {5'h00, start_lba} + {24'h000000, erase_cnt};
   wire        erase_ok  = (erase_end <= {1'b0, CAPACITY});
   wire        data_rd   = tf_req_in.rd && (tf_req_in.addr == TF_DATA)
                           && (state == S_IDENT);
   wire        last_word = (word_idx == ID_LAST_WORD);
   wire [7:0]  idle_stat = STAT_RESET;
   wire [7:0]  abort_st  = STAT_RESET | (8'h01 << ST_ERR_BIT);
   wire [7:0]  fault_st  = abort_st | (8'h01 << ST_DWF_BIT);
   wire [7:0]  busy_st   = 8'h01 << ST_BSY_BIT;
   wire [7:0]  drq_st    = STAT_RESET | (8'h01 << ST_DRQ_BIT);
   wire [15:0] rd_word   = id_rom[word_idx];
   wire [15:0] rd_mux    =
      (tf_req_in.addr == TF_DATA)      ? (data_rd ? rd_word : 16'h0000) :
      (tf_req_in.addr == TF_FEAT_ERR)  ? {8'h00, error}     :
      (tf_req_in.addr == TF_COUNT)     ? {8'h00, count}     :
      (tf_req_in.addr == TF_ADDR_LOW)  ? {8'h00, addr_low}  :
      (tf_req_in.addr == TF_ADDR_MID)  ? {8'h00, addr_mid}  :
      (tf_req_in.addr == TF_ADDR_HIGH) ? {8'h00, addr_high} :
      (tf_req_in.addr == TF_DRV_HEAD)  ? {8'h00, drv_head}  :
                                         {8'h00, status};

   // ------------------------------------------------------------
   // Task file parameter registers
   // ------------------------------------------------------------
   // Writes during a busy command are dropped so parameters stay put
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         feat      <= 8'h00;
         count     <= 8'h00;
         addr_low  <= 8'h00;
         addr_mid  <= 8'h00;
         addr_high <= 8'h00;
         drv_head  <= 8'h00;
      end else if (reg_wr) begin
         unique case (tf_req_in.addr)
            TF_FEAT_ERR:  feat      <= wbyte;
            TF_COUNT:     count     <= wbyte;
            TF_ADDR_LOW:  addr_low  <= wbyte;
            TF_ADDR_MID:  addr_mid  <= wbyte;
            TF_ADDR_HIGH: addr_high <= wbyte;
            TF_DRV_HEAD:  drv_head  <= wbyte;
            TF_DATA, TF_CMD_STAT: ;
         endcase
      end
   end

   // ------------------------------------------------------------
   // Read data
   // ------------------------------------------------------------
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in)
         tf_rdata_out <= 16'h0000;
      else if (tf_req_in.rd)
         tf_rdata_out <= rd_mux;
   end

   // ------------------------------------------------------------
   // Command sequencer
   // ------------------------------------------------------------
   aedf_state_t     next_state;
   logic [7:0]      next_status;
   logic [7:0]      next_error;
   logic [7:0]      next_word_idx;
   aedf_media_req_t next_media;

   always_comb begin
      next_state    = state;
      next_status   = status;
      next_error    = error;
      next_word_idx = word_idx;
      next_media    = media_req_out;
      unique case (state)
         S_IDLE: begin
            if (cmd_take) begin
               next_error = ERR_NONE;
               unique case (wbyte)
                  OP_ERASE: begin
                     // Erase only conditions blocks; no data moves
                     if (erase_ok) begin
                        next_state       = S_ERASE;
                        next_status      = busy_st;
                        next_media.erase = 1'b1;
                        next_media.lba   = start_lba;
                        next_media.count = erase_cnt;
                     end else begin
                        next_status = abort_st;
                        next_error  = ERR_ABORT;
                     end
                  end
                  OP_DIAG: begin
                     next_state      = S_DIAG;
                     next_status     = busy_st;
                     next_media.diag = 1'b1;
                  end
                  OP_FLUSH: begin
                     if (FLUSH_EN) begin
                        next_state       = S_FLUSH;
                        next_status      = busy_st;
                        next_media.flush = 1'b1;
                     end else begin
                        next_status = abort_st;
                        next_error  = ERR_ABORT;
                     end
                  end
                  OP_IDENT: begin
                     next_state    = S_IDENT;
                     next_status   = drq_st;
                     next_word_idx = 8'h00;
                  end
                  default: begin
                     next_status = abort_st;
                     next_error  = ERR_ABORT;
                  end
               endcase
            end
         end
         S_ERASE: begin
            if (media_rsp_in.done) begin
               next_state       = S_IDLE;
               next_media.erase = 1'b0;
               // Fault ends the command without any data phase
               next_status = media_rsp_in.fault ? fault_st
                                                : idle_stat;
               next_error  = media_rsp_in.fault ? ERR_ABORT : ERR_NONE;
            end
         end
         S_DIAG: begin
            if (media_rsp_in.done) begin
               next_state      = S_IDLE;
               next_media.diag = 1'b0;
               next_status     = idle_stat;
               // Code passed straight through from the test engine
               next_error = media_rsp_in.diag_code;
            end
         end
         S_FLUSH: begin
            // Ready only after the media confirms the cache is empty
            if (media_rsp_in.done) begin
               next_state       = S_IDLE;
               next_media.flush = 1'b0;
               next_status      = idle_stat;
            end
         end
         S_IDENT: begin
            if (data_rd) begin
               next_word_idx = word_idx + 8'h01;
               if (last_word) begin
                  next_state  = S_IDLE;
                  next_status = idle_stat;
               end
            end
         end
      endcase
   end

   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         state         <= S_IDLE;
         status        <= STAT_RESET;
         error         <= DIAG_OK;
         word_idx      <= 8'h00;
         media_req_out <= '0;
      end else begin
         state         <= next_state;
         status        <= next_status;
         error         <= next_error;
         word_idx      <= next_word_idx;
         media_req_out <= next_media;
      end
   end

endmodule : aedf_core

// [verif/aedf_core_assertions.sv]
// Port-level assertions for the ATA command interpreter
`timescale 1ns/1ps
module aedf_checker
   import aedf_pkg::*;
(
   input wire logic                      clk_in,
   input wire logic                      reset_in,
   input wire aedf_pkg::aedf_tf_req_t    tf_req_in,
   input wire logic [15:0]               tf_rdata_out,
   input wire aedf_pkg::aedf_media_req_t media_req_out,
   input wire aedf_pkg::aedf_media_rsp_t media_rsp_in
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (reset_in);

   wire [39:0] req  = media_req_out;
   wire        act  = |req[39:37];
   wire        fl   = media_req_out.flush;
   wire        dg   = media_req_out.diag;
   wire        done = media_rsp_in.done;
   wire [2:0]  ad   = tf_req_in.addr;
   wire [7:0]  op   = tf_req_in.wdata[7:0];
   // Only commands seen while no media job runs count as accepted
   wire        cmd  = tf_req_in.wr && ad == TF_CMD_STAT && !act;
   wire        rd_e = tf_req_in.rd && ad == TF_FEAT_ERR;
   wire        rd_s = tf_req_in.rd && ad == TF_CMD_STAT;

   a_one_request: assert property ($onehot0(req[39:37]))
      else $error("more than one media job at once");
   a_req_held: assert property (act && !done |=> $stable(req))
      else $error("media request changed before done");
   a_req_drop: assert property (act && done |=> !act)
      else $error("media request kept after done");
   a_diag_start: assert property (cmd && op == OP_DIAG |=> dg)
      else $error("diagnostic not started");
   a_code_late: assert property (dg && !done && rd_e |=>
      tf_rdata_out == 16'h0000)
      else $error("diagnostic code shown early");
   a_flush_start: assert property (cmd && op == OP_FLUSH |=> fl)
      else $error("flush not started");
   a_flush_busy: assert property (fl && !done && rd_s |=>
      tf_rdata_out == 16'h0080)
      else $error("ready shown during flush");
   a_ident_word: assert property (cmd && op == OP_IDENT ##1
      tf_req_in.rd && ad == TF_DATA |=> tf_rdata_out == 16'h044a)
      else $error("identify word 0 wrong");
   a_rdata_hold: assert property (!tf_req_in.rd |=> $stable(tf_rdata_out))
      else $error("read data moved without a read");
endmodule : aedf_checker

// [verif/aedf_media_model.sv]
// Behavioural media back end answering erase, flush and diagnostic
`timescale 1ns/1ps
module aedf_media_model (
   input  wire logic                      clk_in,
   input  wire logic                      reset_in,
   input  wire aedf_pkg::aedf_media_req_t req_in,
   input  wire logic [7:0]                wait_in,
   input  wire logic                      fault_in,
   input  wire logic [7:0]                code_in,
   output aedf_pkg::aedf_media_rsp_t      rsp_out
);
   logic [7:0] cnt;
   wire        busy = req_in.erase | req_in.flush | req_in.diag;

   // Work ends only after the chosen delay; lines carry junk otherwise
   assign rsp_out.done      = busy && cnt == wait_in;
   assign rsp_out.fault     = rsp_out.done ? fault_in : ~fault_in;
   assign rsp_out.diag_code = rsp_out.done ? code_in : ~code_in;

   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in)
         cnt <= 8'h00;
      else
         cnt <= (busy && !rsp_out.done) ? cnt + 8'h01 : 8'h00;
   end
endmodule : aedf_media_model

// [verif/ata_erase_diag_flush_identify_test.sv]
// Self-checking bench for the ATA command interpreter
`timescale 1ns/1ps
module ata_erase_diag_flush_identify_test;
   import aedf_pkg::*;
   localparam logic [31:0]  CAP = 32'h0000_1000;
   localparam logic [159:0] SER = {{12{8'h20}}, "TB000042"};
   localparam logic [63:0]  FWR = "TBREV001";
   localparam logic [319:0] MDL = {{32{8'h20}}, "TESTDISK"};
   logic            clk_in = 1'b0;
   logic            reset_in = 1'b1;
   aedf_tf_req_t    tf_req = '0;
   logic [15:0]     rdat;
   aedf_media_req_t mq;
   aedf_media_rsp_t mrsp;
   logic            fault = 1'b0;
   logic [7:0]      code = 8'h01;
   logic [7:0]      lat = 8'h14;
   int              err_count = 0;
   int              num_checks = 0;
   wire  [39:0]     flags = {37'h0, mq[39:37]};
   wire  [39:0]     rd40 = {24'h0, rdat};

   always #2.5 clk_in = ~clk_in;

   aedf_core #(.CAPACITY(CAP), .SERIAL(SER), .FW_REV(FWR), .MODEL(MDL))
      uut (.clk_in(clk_in), .reset_in(reset_in), .tf_req_in(tf_req),
           .tf_rdata_out(rdat), .media_req_out(mq), .media_rsp_in(mrsp));
   aedf_media_model media (.clk_in(clk_in), .reset_in(reset_in),
      .req_in(mq), .wait_in(lat), .fault_in(fault), .code_in(code),
      .rsp_out(mrsp));

   task automatic chk(input string n, input logic [39:0] e, g);
      num_checks++;
      if (g !== e) begin
         err_count++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask : chk

   task automatic acc(input logic [2:0] a, input logic w, input logic [7:0] d);
      @(negedge clk_in);
      tf_req = '{a, w, !w, {8'h00, d}};
      @(negedge clk_in);
      tf_req = '0;
   endtask : acc

   // Bounded poll, so a stuck busy flag cannot hang the run
   task automatic chk_se(input bit w, input logic [7:0] s, e);
      for (int i = 0; w && i < 200; i++) begin
         acc(TF_CMD_STAT, 1'b0, 8'h00);
         if (rdat[7] === 1'b0) break;
      end
      acc(TF_CMD_STAT, 1'b0, 8'h00);
      chk("status", {32'h0, s}, rd40);
      acc(TF_FEAT_ERR, 1'b0, 8'h00);
      chk("error", {32'h0, e}, rd40);
   endtask : chk_se

   task automatic erase(input logic [7:0] dh, lo, cn);
      acc(TF_DRV_HEAD, 1'b1, dh);
      acc(TF_ADDR_MID, 1'b1, 8'h0f);
      acc(TF_ADDR_LOW, 1'b1, lo);
      acc(TF_COUNT, 1'b1, cn);
      acc(TF_CMD_STAT, 1'b1, OP_ERASE);
   endtask : erase

   function automatic logic [39:0] ew(input int k);
      case (k) inside
         0:       return 40'h044a;
         7:       return {24'h0, CAP[31:16]};
         8:       return {24'h0, CAP[15:0]};
         [10:19]: return {24'h0, SER[319 - 16 * k -: 16]};
         20, 21:  return 40'h0002;
         [23:26]: return {24'h0, FWR[431 - 16 * k -: 16]};
         [27:46]: return {24'h0, MDL[751 - 16 * k -: 16]};
         47:      return 40'h8001;
         49:      return 40'h0f00;
         default: return 40'h0000;
      endcase
   endfunction : ew

   task automatic t_erase;
      chk_se(1'b0, 8'h50, 8'h01);
      erase(8'h00, 8'hf0, 8'h10);
      chk("media req", {3'b100, 28'h0000ff0, 9'h010}, mq);
      chk_se(1'b0, 8'h80, 8'h00);
      chk_se(1'b1, 8'h50, 8'h00);
      fault = 1'b1;
      lat = 8'h00;
      erase(8'h00, 8'h00, 8'h00);
      chk("media req", {3'b100, 28'h0000f00, 9'h100}, mq);
      chk_se(1'b1, 8'h71, 8'h04);
      fault = 1'b0;
      lat = 8'h14;
      erase(8'h00, 8'hf1, 8'h10);
      chk("past end", 40'h0, flags);
      chk_se(1'b0, 8'h51, 8'h04);
      erase(8'h10, 8'h00, 8'h01);
      chk("other drive", 40'h0, flags);
      $display("erase test done");
   endtask : t_erase

   task automatic t_diag;
      acc(TF_DRV_HEAD, 1'b1, 8'h10);
      for (int c = 1; c <= 5; c++) begin
         code = 8'(c);
         acc(TF_CMD_STAT, 1'b1, OP_DIAG);
         chk("diag req", 40'h1, flags);
         acc(TF_FEAT_ERR, 1'b0, 8'h00);
         chk("early code", 40'h0, rd40);
         chk_se(1'b1, 8'h50, code);
      end
      $display("diag test done");
   endtask : t_diag

   task automatic t_flush;
      acc(TF_DRV_HEAD, 1'b1, 8'h00);
      acc(TF_COUNT, 1'b1, 8'h33);
      acc(TF_CMD_STAT, 1'b1, OP_FLUSH);
      chk("flush req", 40'h2, flags);
      // Parameter writes must be dropped while a command runs
      acc(TF_COUNT, 1'b1, 8'h5a);
      chk_se(1'b0, 8'h80, 8'h00);
      chk_se(1'b1, 8'h50, 8'h00);
      acc(TF_COUNT, 1'b0, 8'h00);
      chk("busy write", 40'h33, rd40);
      // Opcode outside the handled set is aborted
      acc(TF_CMD_STAT, 1'b1, 8'hff);
      chk_se(1'b0, 8'h51, 8'h04);
      $display("flush test done");
   endtask : t_flush

   task automatic t_ident;
      @(negedge clk_in);
      tf_req = '{TF_CMD_STAT, 1'b1, 1'b0, {8'h00, OP_IDENT}};
      for (int k = 0; k <= 256; k++) begin
         @(negedge clk_in);
         tf_req = '{TF_DATA, 1'b0, k < 256, 16'h0000};
         if (k > 0)
            chk("ident word", ew(k - 1), rd40);
      end
      chk_se(1'b0, 8'h50, 8'h00);
      $display("identify test done");
   endtask : t_ident

   task automatic finish_test;
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : finish_test

   initial begin
      repeat (16) @(negedge clk_in);
      reset_in = 1'b0;
      t_erase;
      t_diag;
      t_flush;
      t_ident;
      finish_test;
   end

   // The whole sequence needs a few hundred cycles
   initial begin
      #100000;
      err_count++;
      finish_test;
   end
endmodule : ata_erase_diag_flush_identify_test

bind aedf_core aedf_checker chk_i (.clk_in(clk_in), .reset_in(reset_in),
   .tf_req_in(tf_req_in), .tf_rdata_out(tf_rdata_out),
   .media_req_out(media_req_out), .media_rsp_in(media_rsp_in));
